// ==== bfcd_decoder.sv ====
// Boot fuse and boot pin configuration decoder with AHB-Lite status port
//
// Local design decisions: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module bfcd_decoder (
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              rst_n,
  // Boot selection pins
  input  wire logic [3:0]        bootPins,
  // Fuse array read port
  output logic                   fuseRdReq,
  output var  logic [11:0]       fuseAddr,
  input  wire logic              fuseAck,
  input  wire logic [31:0]       fuseData,
  // Digest port for authentication
  input  wire logic [2:0]        digestIdx,
  output logic [31:0]            digestWord,
  // Decoded configuration
  output var  bfcd_pkg::bfcdCfg_t cfg,
  output var  logic              cfgValid,
  // AHB-Lite slave
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic                   hresp,
  output var  logic [31:0]       hrdata
);
  import bfcd_pkg::*;

  typedef enum logic [1:0] {
    BFCD_ST_REQ    = 2'b00,
    BFCD_ST_DECODE = 2'b01,
    BFCD_ST_DONE   = 2'b10
  } bfcdState_t;

  typedef struct packed {
    logic [15:0] zero;
    logic [3:0]  pins;
    logic        secReserved;
    bfcdSec_t    sec;
    logic        toDownloader;
    logic        fuseSourced;
    logic [3:0]  device;
    bfcdMode_t   mode;
    logic        valid;
  } bfcdStatus_t;

  typedef struct packed {
    logic [7:0]  zero;
    logic [15:0] wdogTimeoutMs;
    logic        wdogOn;
    logic        lpbPolarity;
    bfcdLpb_t    lpbDiv;
    logic        dcacheOff;
    logic        icacheOff;
    logic        recoveryEn;
    logic        digestHidden;
  } bfcdBootCfg_t;

  typedef struct packed {
    logic [10:0] zero;
    logic [10:0] secondaryOffsetMb;
    logic        secondaryNorOk;
    logic        secondaryEn;
    logic        pad;
    logic [6:0]  cardDelay;
  } bfcdCard_t;

  // Fuse value one is a blown fuse
  function automatic logic isBlown(input logic fuseBit);
    return fuseBit == 1'b1;
  endfunction

  function automatic logic [11:0] loadAddr(input logic [3:0] idx);
    logic [3:0] digOff;
    digOff = 4'(idx - LOAD_FIRST_DIG);
    case (idx)
      4'h0:    loadAddr = FUSE_SEC_WORD;
      4'h1:    loadAddr = FUSE_CFG0_WORD;
      4'h2:    loadAddr = FUSE_CFG1_WORD;
      4'h3:    loadAddr = FUSE_CFG2_WORD;
      4'h4:    loadAddr = FUSE_PAD_WORD;
      default: loadAddr = 12'(FUSE_DIG_FIRST + 12'(digOff) * FUSE_DIG_STEP);
    endcase
  endfunction

  // n==2 gives 1 MB although the power-of-two series would give 4 MB
  function automatic logic [10:0] secOffset(input logic [3:0] n);
    if (n == 4'h0) begin
      secOffset = SECOFF_N0_MB;
    end else if (n == 4'h2) begin
      secOffset = SECOFF_N2_MB;
    end else if (n <= SECOFF_N_MAX) begin
      secOffset = 11'(11'h001 << n);
    end else begin
      secOffset = 11'h000;
    end
  endfunction

  function automatic bfcdPad_t padSplit(input logic [31:0] word);
    return bfcdPad_t'(word[PAD_HI:PAD_LO]);
  endfunction

  bfcdState_t  stateReg;
  logic [3:0]  loadIdxReg;
  logic [31:0] secWordReg;
  logic [31:0] cfg0WordReg;
  logic [31:0] cfg1WordReg;
  logic [31:0] cfg2WordReg;
  logic [31:0] padWordReg;
  logic [3:0]  pinSync1;
  logic [3:0]  pinSync2;
  logic [3:0]  sampledPinsReg;
  logic        armedReg;
  bfcdCfg_t    cfgNext;
  logic        digestWr;
  logic [31:0] busDigest;
  logic        busyReg;
  logic        dpWriteReg;
  logic [7:0]  dpAddrReg;
  logic        hideReg;
  logic        accept;
  logic [31:0] readMux;

  // Pins are asynchronous, two flops before any use
  always_ff @(posedge mclk) begin
    pinSync1 <= bootPins;
    pinSync2 <= pinSync1;
  end

  // Caught on the first edge after release, never again
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      armedReg       <= 1'b1;
      sampledPinsReg <= 4'h0;
    end else if (armedReg) begin
      armedReg       <= 1'b0;
      sampledPinsReg <= pinSync2;
    end
  end

  // Fuse load sequence
  assign fuseRdReq = (stateReg == BFCD_ST_REQ);
  assign digestWr  = fuseRdReq && fuseAck && (loadIdxReg >= LOAD_FIRST_DIG);

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      stateReg   <= BFCD_ST_REQ;
      loadIdxReg <= 4'h0;
    end else begin
      case (stateReg)
        BFCD_ST_REQ: begin
          if (fuseAck) begin
            loadIdxReg <= 4'(loadIdxReg + 4'h1);
            if (loadIdxReg == LOAD_LAST) begin
              stateReg <= BFCD_ST_DECODE;
            end
          end
        end
        BFCD_ST_DECODE: stateReg <= BFCD_ST_DONE;
        BFCD_ST_DONE:   stateReg <= BFCD_ST_DONE;
        default:        stateReg <= BFCD_ST_REQ;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      fuseAddr <= FUSE_SEC_WORD;
    end else if (fuseRdReq && fuseAck) begin
      fuseAddr <= loadAddr(4'(loadIdxReg + 4'h1));
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      secWordReg  <= 32'h0000_0000;
      cfg0WordReg <= 32'h0000_0000;
      cfg1WordReg <= 32'h0000_0000;
      cfg2WordReg <= 32'h0000_0000;
      padWordReg  <= 32'h0000_0000;
    end else if (fuseRdReq && fuseAck) begin
      case (loadIdxReg)
        4'h0:    secWordReg  <= fuseData;
        4'h1:    cfg0WordReg <= fuseData;
        4'h2:    cfg1WordReg <= fuseData;
        4'h3:    cfg2WordReg <= fuseData;
        4'h4:    padWordReg  <= fuseData;
        default: secWordReg  <= secWordReg;
      endcase
    end
  end

  // Digest words go to the memory, port B feeds authentication
  bfcd_digest_ram #(
    .DEPTH(8),
    .WIDTH(32)
  ) u_digest (
    .mclk    (mclk),
    .wrEn    (digestWr),
    .wrIdx   (3'(loadIdxReg - LOAD_FIRST_DIG)),
    .wrData  (fuseData),
    .rdIdxA  (haddr[4:2]),
    .rdDataA (busDigest),
    .rdIdxB  (digestIdx),
    .rdDataB (digestWord)
  );

  // Decode of the collected words
  always_comb begin
    logic        srcBlown;
    logic        force_;
    logic [3:0]  selBits;
    logic [3:0]  n;
    srcBlown = isBlown(cfg0WordReg[SRC_SEL_BIT]);
    force_   = isBlown(cfg1WordReg[FORCE_BIT]);
    n        = cfg2WordReg[SECOFF_HI:SECOFF_LO];
    cfgNext  = '0;
    // Forced fuse boot takes the selector from fuses
    selBits  = force_ ? cfg0WordReg[FMODE_HI:FMODE_LO] : sampledPinsReg;
    cfgNext.mode = bfcdMode_t'(selBits[1:0]);
    case (cfgNext.mode)
      BFCD_MODE_FUSES: begin
        cfgNext.device       = cfg0WordReg[FDEV_HI:FDEV_LO];
        cfgNext.fuseSourced  = 1'b1;
        cfgNext.toDownloader = !srcBlown;
      end
      BFCD_MODE_INTERNAL: begin
        cfgNext.fuseSourced = srcBlown;
        cfgNext.device = srcBlown ? cfg0WordReg[FDEV_HI:FDEV_LO] : sampledPinsReg;
      end
      default: begin
        cfgNext.device = selBits;
      end
    endcase
    cfgNext.sec = cfg0WordReg[SEC1_BIT] ? BFCD_SEC_CLOSED :
                  (secWordReg[SEC0_BIT] ? BFCD_SEC_OPEN : BFCD_SEC_RSVD);
    cfgNext.secReserved = (cfgNext.sec == BFCD_SEC_RSVD);
    cfgNext.recoveryEn  = isBlown(cfg1WordReg[RECOV_BIT]);
    cfgNext.icacheOff   = isBlown(cfg1WordReg[ICACHE_BIT]);
    cfgNext.dcacheOff   = isBlown(cfg1WordReg[DCACHE_BIT]);
    case (cfg1WordReg[LPB_HI:LPB_LO])
      2'h2:    cfgNext.lpbDiv = BFCD_LPB_DIV2;
      2'h3:    cfgNext.lpbDiv = BFCD_LPB_DIV4;
      default: cfgNext.lpbDiv = BFCD_LPB_OFF;
    endcase
    cfgNext.lpbPolarity = cfg1WordReg[LPB_POL_BIT];
    cfgNext.wdogOn      = isBlown(cfg1WordReg[WDOG_EN_BIT]);
    case (cfg1WordReg[WDOG_TO_HI:WDOG_TO_LO])
      2'h0:    cfgNext.wdogTimeoutMs = WDOG_MS_00;
      2'h1:    cfgNext.wdogTimeoutMs = WDOG_MS_01;
      2'h2:    cfgNext.wdogTimeoutMs = WDOG_MS_10;
      default: cfgNext.wdogTimeoutMs = WDOG_MS_11;
    endcase
    cfgNext.cardDelay         = cfg2WordReg[DLY_HI:DLY_LO];
    cfgNext.secondaryEn       = (n <= SECOFF_N_MAX);
    cfgNext.secondaryNorOk    = (n <= SECOFF_NOR_MAX);
    cfgNext.secondaryOffsetMb = secOffset(n);
    cfgNext.cardPad           = padSplit(cfg2WordReg);
    cfgNext.nandPad           = padSplit(padWordReg);
  end

  // Registered once; later fuse or pin activity cannot disturb it
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cfg      <= '0;
      cfgValid <= 1'b0;
    end else if (stateReg == BFCD_ST_DECODE) begin
      cfg      <= cfgNext;
      cfgValid <= 1'b1;
    end
  end

  // Bus slave: one wait state on every NONSEQ access
  assign accept    = hsel && hready && (htrans == HTRANS_NONSEQ);
  assign hreadyout = !busyReg;
  assign hresp     = HRESP_OKAY;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      busyReg    <= 1'b0;
      dpWriteReg <= 1'b0;
      dpAddrReg  <= 8'h00;
    end else begin
      busyReg <= accept;
      if (accept) begin
        dpWriteReg <= hwrite;
        dpAddrReg  <= haddr[7:0];
      end
    end
  end

  // Hiding the digest is sticky so boot software can lock it away
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      hideReg <= 1'b0;
    end else if (busyReg && dpWriteReg && dpAddrReg == REG_CTRL && hwdata[CTRL_HIDE_BIT]) begin
      hideReg <= 1'b1;
    end
  end

  always_comb begin
    bfcdStatus_t  st;
    bfcdBootCfg_t bc;
    bfcdCard_t    cd;
    st = '0;
    bc = '0;
    cd = '0;
    st.valid = cfgValid;
    st.mode = cfg.mode;
    st.device = cfg.device;
    st.fuseSourced = cfg.fuseSourced;
    st.toDownloader = cfg.toDownloader;
    st.sec = cfg.sec;
    st.secReserved = cfg.secReserved;
    st.pins = sampledPinsReg;
    bc.digestHidden = hideReg;
    bc.recoveryEn = cfg.recoveryEn;
    bc.icacheOff = cfg.icacheOff;
    bc.dcacheOff = cfg.dcacheOff;
    bc.lpbDiv = cfg.lpbDiv;
    bc.lpbPolarity = cfg.lpbPolarity;
    bc.wdogOn = cfg.wdogOn;
    bc.wdogTimeoutMs = cfg.wdogTimeoutMs;
    cd.cardDelay = cfg.cardDelay;
    cd.secondaryEn = cfg.secondaryEn;
    cd.secondaryNorOk = cfg.secondaryNorOk;
    cd.secondaryOffsetMb = cfg.secondaryOffsetMb;
    if (dpAddrReg >= REG_DIG_FIRST && dpAddrReg <= REG_DIG_LAST) begin
      readMux = hideReg ? 32'h0000_0000 : busDigest;
    end else begin
      case (dpAddrReg)
        REG_STATUS:  readMux = 32'(st);
        REG_CTRL:    readMux = {31'h0000_0000, hideReg};
        REG_BOOTCFG: readMux = 32'(bc);
        REG_CARD:    readMux = 32'(cd);
        REG_PADS:    readMux = {16'h0000, cfg.nandPad, cfg.cardPad};
        default:     readMux = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      hrdata <= 32'h0000_0000;
    end else if (busyReg && !dpWriteReg) begin
      hrdata <= readMux;
    end
  end

  // Checks
  a_pins_held: assert property (@(posedge mclk) disable iff (!rst_n)
    !armedReg |=> $stable(sampledPinsReg)) else $error("sampled pins changed");
  a_cfg_frozen: assert property (@(posedge mclk) disable iff (!rst_n)
    cfgValid |=> cfgValid && $stable(cfg)) else $error("config changed after valid");
  a_fuse_only: assert property (@(posedge mclk) disable iff (!rst_n)
    cfgValid && cfg.mode == BFCD_MODE_FUSES |-> cfg.device == cfg0WordReg[FDEV_HI:FDEV_LO])
    else $error("fuse mode used pins");
  a_pin_override: assert property (@(posedge mclk) disable iff (!rst_n)
    cfgValid && cfg.mode == BFCD_MODE_INTERNAL && !cfg0WordReg[SRC_SEL_BIT]
    |-> cfg.device == sampledPinsReg && !cfg.fuseSourced) else $error("pins not used");
  a_to_downloader: assert property (@(posedge mclk) disable iff (!rst_n)
    cfgValid |-> cfg.toDownloader == (cfg.mode == BFCD_MODE_FUSES && !cfg0WordReg[SRC_SEL_BIT]))
    else $error("downloader diversion wrong");
  a_sec_flag: assert property (@(posedge mclk) disable iff (!rst_n)
    cfgValid |-> cfg.secReserved == (!cfg0WordReg[SEC1_BIT] && !secWordReg[SEC0_BIT]))
    else $error("reserved security flag wrong");
  a_force_mode: assert property (@(posedge mclk) disable iff (!rst_n)
    cfgValid && cfg1WordReg[FORCE_BIT] |-> cfg.mode == cfg0WordReg[FMODE_LO+1:FMODE_LO])
    else $error("forced mode not from fuses");
  a_wdog_fast: assert property (@(posedge mclk) disable iff (!rst_n)
    cfgValid && cfg1WordReg[WDOG_TO_HI:WDOG_TO_LO] == 2'h3 |-> cfg.wdogTimeoutMs == WDOG_MS_11)
    else $error("watchdog timeout wrong");
  a_second_off: assert property (@(posedge mclk) disable iff (!rst_n)
    cfgValid && cfg2WordReg[SECOFF_HI:SECOFF_LO] > SECOFF_N_MAX |-> !cfg.secondaryEn)
    else $error("secondary boot not disabled");
  a_cache_bits: assert property (@(posedge mclk) disable iff (!rst_n)
    cfgValid |-> cfg.icacheOff == cfg1WordReg[ICACHE_BIT]
    && cfg.dcacheOff == cfg1WordReg[DCACHE_BIT]) else $error("cache enables wrong");
  a_bus_wait: assert property (@(posedge mclk) disable iff (!rst_n)
    accept |=> !hreadyout ##1 hreadyout) else $error("bus wait state wrong");

endmodule
`default_nettype wire

// ==== bfcd_decoder_bench.sv ====
// Self-checking bench for the boot fuse configuration decoder
`timescale 1ns/1ps
`default_nettype none
module bfcd_decoder_bench;
  import bfcd_pkg::*;
  typedef struct packed {
    logic [3:0]  pins;
    logic [31:0] w450;
    logic [31:0] w470;
    logic [31:0] w480;
    logic [1:0]  mode;
    logic [3:0]  dev;
    logic        src;
    logic        dl;
    logic [1:0]  sec;
    logic        rsv;
  } bfcdRow_t;
  logic        mclk, rst_n, slow, fuseRdReq, fuseAck, cfgValid;
  logic        hsel, hwrite, hreadyout, hresp;
  logic [3:0]  bootPins;
  logic [11:0] fuseAddr;
  logic [31:0] fuseData, digestWord, haddr, hwdata, hrdata, rd, s;
  logic [2:0]  digestIdx;
  logic [1:0]  htrans;
  bfcdCfg_t    cfg, saved;
  int          failures, nChecks;
  // Rows: pins, security word, config words, expected mode/device/source/downloader/security
  bfcdRow_t rows [7] = '{
    '{4'h2, 32'h0, 32'h0, 32'h0, 2'h2, 4'h2, 1'b0, 1'b0, 2'h0, 1'b1},
    '{4'hC, 32'h0002_0000, 32'h50, 32'h0, 2'h0, 4'h5, 1'b1, 1'b1, 2'h1, 1'b0},
    '{4'h0, 32'h0, 32'h1200_0000, 32'h0, 2'h0, 4'h0, 1'b1, 1'b0, 2'h2, 1'b0},
    '{4'hE, 32'h0002_0000, 32'h1200_0050, 32'h0, 2'h2, 4'h5, 1'b1, 1'b0, 2'h2, 1'b0},
    '{4'h1, 32'h0, 32'h1000_0200, 32'h0010_0000, 2'h2, 4'h0, 1'b1, 1'b0, 2'h0, 1'b1},
    '{4'h5, 32'h0002_0000, 32'h0, 32'h0, 2'h1, 4'h5, 1'b0, 1'b0, 2'h1, 1'b0},
    '{4'hB, 32'h0, 32'h0200_0000, 32'h0, 2'h3, 4'hB, 1'b0, 1'b0, 2'h2, 1'b0}};
  logic [15:0] msTab [4] = '{WDOG_MS_00, WDOG_MS_01, WDOG_MS_10, WDOG_MS_11};
  logic [1:0]  lpbTab [4] = '{BFCD_LPB_OFF, BFCD_LPB_OFF, BFCD_LPB_DIV2, BFCD_LPB_DIV4};
  logic [3:0]  nTab [4] = '{4'h0, 4'h2, 4'h8, 4'hB};
  logic [10:0] offTab [4] = '{11'h004, 11'h001, 11'h100, 11'h000};

  bfcd_decoder u_bfcd_decoder (.mclk(mclk), .rst_n(rst_n), .bootPins(bootPins),
    .fuseRdReq(fuseRdReq), .fuseAddr(fuseAddr), .fuseAck(fuseAck), .fuseData(fuseData),
    .digestIdx(digestIdx), .digestWord(digestWord), .cfg(cfg), .cfgValid(cfgValid),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata));
  bfcd_fuse_model u_bfcd_fuse_model (.mclk(mclk), .slow(slow), .fuseRdReq(fuseRdReq),
    .fuseAddr(fuseAddr), .fuseAck(fuseAck), .fuseData(fuseData));

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nChecks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    $display("checks=%0d failures=%0d", nChecks, failures);
    if (failures == 0 && nChecks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Single word transfer; waits on the slave, never on a fixed count
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel   <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr  <= {24'h0, a};
    hwrite <= wr;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk({31'h0, hresp}, {31'h0, HRESP_OKAY});
  endtask

  // Pins stand well before reset release, then wait for the decode
  task automatic boot(input logic [3:0] p, input logic [31:0] w0, w1, w2, w3, w4,
                      input logic sl);
    int n;
    n = 0;
    bootPins <= p;
    slow     <= sl;
    u_bfcd_fuse_model.words[0] = w0;
    u_bfcd_fuse_model.words[1] = w1;
    u_bfcd_fuse_model.words[2] = w2;
    u_bfcd_fuse_model.words[3] = w3;
    u_bfcd_fuse_model.words[4] = w4;
    rst_n <= 1'b0;
    repeat (4) @(posedge mclk);
    chk({30'h0, cfgValid, fuseRdReq}, 32'h1);
    rst_n <= 1'b1;
    while (cfgValid !== 1'b1 && n < 300) begin
      @(posedge mclk);
      n++;
    end
    chk({30'h0, cfgValid, fuseRdReq}, 32'h2);
  endtask

  initial begin
    rst_n = 1'b0; slow = 1'b0; bootPins = 4'h2; digestIdx = 3'h0;
    hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0; hwdata = 32'h0;
    failures = 0; nChecks = 0;
    for (int i = 0; i < 8; i++) u_bfcd_fuse_model.words[5 + i] = 32'hD16E_0000 + i;
    repeat (2) @(posedge mclk);
    chk({31'h0, cfgValid}, 32'h0);
    chk({20'h0, fuseAddr}, {20'h0, FUSE_SEC_WORD});
    foreach (rows[i]) begin
      boot(rows[i].pins, rows[i].w450, rows[i].w470, rows[i].w480, 32'h0, 32'h0, i[0]);
      chk({30'h0, cfg.mode}, {30'h0, rows[i].mode});
      chk({28'h0, cfg.device}, {28'h0, rows[i].dev});
      chk({31'h0, cfg.fuseSourced}, {31'h0, rows[i].src});
      chk({31'h0, cfg.toDownloader}, {31'h0, rows[i].dl});
      chk({30'h0, cfg.sec}, {30'h0, rows[i].sec});
      chk({31'h0, cfg.secReserved}, {31'h0, rows[i].rsv});
    end
    for (int i = 0; i < 4; i++) begin
      boot(4'h2, 32'h0, 32'h1000_0000, {14'h0, i[1:0], i[1:0], 5'h0, i[0], 8'h0},
           {9'h0, nTab[i], 19'h0}, 32'h0, i[1]);
      chk({16'h0, cfg.wdogTimeoutMs}, {16'h0, msTab[i]});
      chk({30'h0, cfg.lpbDiv}, {30'h0, lpbTab[i]});
      chk({31'h0, cfg.dcacheOff}, {31'h0, i[0]});
      chk({21'h0, cfg.secondaryOffsetMb}, {21'h0, offTab[i]});
      chk({30'h0, cfg.secondaryEn, cfg.secondaryNorOk}, {30'h0, i < 3, i < 2});
      chk({30'h0, cfg.wdogOn, cfg.recoveryEn}, 32'h0);
    end
    boot(4'h2, 32'h0, 32'h1000_0000, 32'h0200_3400, 32'hA500_5A00, 32'h3C00_0000, 1'b1);
    chk({30'h0, cfg.recoveryEn, cfg.wdogOn}, 32'h3);
    chk({30'h0, cfg.icacheOff, cfg.lpbPolarity}, 32'h3);
    chk({25'h0, cfg.cardDelay}, 32'h5A);
    chk({16'h0, cfg.cardPad, cfg.nandPad}, 32'hA53C);
    for (int i = 0; i < 8; i++) begin
      digestIdx <= i[2:0];
      repeat (2) @(posedge mclk);
      chk(digestWord, 32'hD16E_0000 + i);
      ahb(1'b0, REG_DIG_FIRST + {3'h0, i[2:0], 2'h0}, 32'h0);
      chk(rd, 32'hD16E_0000 + i);
    end
    // Pins moving after release must change nothing
    saved = cfg;
    ahb(1'b0, REG_STATUS, 32'h0);
    s = rd;
    bootPins <= 4'hD;
    repeat (10) @(posedge mclk);
    ahb(1'b1, REG_STATUS, 32'hFFFF_FFFF);
    ahb(1'b0, REG_STATUS, 32'h0);
    chk(rd, s);
    chk({16'h0, rd[15:12], 11'h0, rd[0]}, 32'h2001);
    chk(32'(cfg === saved), 32'h1);
    ahb(1'b1, REG_CTRL, 32'h1);
    ahb(1'b0, REG_DIG_FIRST, 32'h0);
    chk(rd, 32'h0);
    ahb(1'b0, REG_BOOTCFG, 32'h0);
    chk({31'h0, rd[0]}, 32'h1);
    ahb(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h0);
    conclude();
  end

  initial begin
    repeat (20000) @(posedge mclk);
    failures++;
    conclude();
  end
endmodule
`default_nettype wire

// ==== bfcd_digest_ram.sv ====
// Small memory holding the root key digest, two registered read ports
`timescale 1ns/1ps
`default_nettype none
module bfcd_digest_ram #(
  parameter int DEPTH = 8,
  parameter int WIDTH = 32,
  parameter int AW    = $clog2(DEPTH)
) (
  // Clock
  input  wire logic             mclk,
  // Write port
  input  wire logic             wrEn,
  input  wire logic [AW-1:0]    wrIdx,
  input  wire logic [WIDTH-1:0] wrData,
  // Read port A
  input  wire logic [AW-1:0]    rdIdxA,
  output var  logic [WIDTH-1:0] rdDataA,
  // Read port B
  input  wire logic [AW-1:0]    rdIdxB,
  output var  logic [WIDTH-1:0] rdDataB
);

  logic [WIDTH-1:0] mem [DEPTH];

  // Contents are data only, no reset needed
  always_ff @(posedge mclk) begin
    if (wrEn) begin
      mem[wrIdx] <= wrData;
    end
  end

  always_ff @(posedge mclk) begin
    rdDataA <= mem[rdIdxA];
    rdDataB <= mem[rdIdxB];
  end

endmodule
`default_nettype wire

// ==== bfcd_fuse_model.sv ====
// Fuse array model answering the decoder's word reads
`timescale 1ns/1ps
`default_nettype none
module bfcd_fuse_model (
  // Clock and pace
  input  wire logic        mclk,
  input  wire logic        slow,
  // Fuse read port
  input  wire logic        fuseRdReq,
  input  wire logic [11:0] fuseAddr,
  output var  logic        fuseAck,
  output var  logic [31:0] fuseData
);
  import bfcd_pkg::*;
  logic [31:0] words [13];
  logic [1:0]  waitCnt;
  initial begin
    fuseAck  = 1'b0;
    fuseData = 32'h0;
    waitCnt  = 2'h0;
  end
  // Digest words follow the fixed words at a 0x10 stride
  function automatic int slot(input logic [11:0] a);
    if (a >= FUSE_DIG_FIRST) return 5 + int'((a - FUSE_DIG_FIRST) >> 4);
    return (a == FUSE_SEC_WORD) ? 0 : (a == FUSE_CFG0_WORD) ? 1 :
           (a == FUSE_CFG1_WORD) ? 2 : (a == FUSE_CFG2_WORD) ? 3 : 4;
  endfunction
  // Stored bit one is a blown fuse; outside an answer the data toggles
  always @(posedge mclk) begin
    if (fuseRdReq && !fuseAck && (!slow || waitCnt == 2'h3)) begin
      fuseAck  <= 1'b1;
      fuseData <= words[slot(fuseAddr)];
      waitCnt  <= 2'h0;
    end else begin
      fuseAck  <= 1'b0;
      fuseData <= ~fuseData;
      waitCnt  <= fuseRdReq ? waitCnt + 2'h1 : 2'h0;
    end
  end
endmodule
`default_nettype wire

// ==== bfcd_pkg.sv ====
// Package of constants and carrier types for the boot fuse configuration decoder
// Behaviour
// - Latch boot pins once at reset release
// - Selector 10 selects internal boot mode
// - Selector 00 uses fuses only, pins ignored
// - Internal mode: source fuse picks fuses or pins
// - Fuse mode, source fuse intact: go downloader
// - Security 00 reserved, 01 open, 1x closed
// - Read 256-bit root key digest for authentication
// - Recovery fuse enables serial flash recovery boot
// - Force fuse boot takes mode from fuses
// - Instruction cache off fuse disables it during boot
// - Data cache off fuse disables data cache
// - Low-power divider code and pad polarity decoded
// - Watchdog counter on only when fuse blown
// - Watchdog timeout code maps to 2/1.5/1/0.5 s
// - Card delay line takes seven fuse bits
// - Secondary image offset decode, large n disables
// - Pad override byte split into pad fields
// - Fuse bit one means blown, zero intact
// - Overridable fields follow pins when source fuse intact
// - Four boot pins are inputs, may override fuses
package bfcd_pkg;

  // Fuse word addresses
  localparam logic [11:0] FUSE_SEC_WORD  = 12'h450;
  localparam logic [11:0] FUSE_CFG0_WORD = 12'h470;
  localparam logic [11:0] FUSE_CFG1_WORD = 12'h480;
  localparam logic [11:0] FUSE_CFG2_WORD = 12'h490;
  localparam logic [11:0] FUSE_PAD_WORD  = 12'h4A0;
  localparam logic [11:0] FUSE_DIG_FIRST = 12'h580;
  localparam logic [11:0] FUSE_DIG_STEP  = 12'h010;
  localparam logic [3:0]  LOAD_FIRST_DIG = 4'h5;
  localparam logic [3:0]  LOAD_LAST      = 4'hC;

  // Fuse bit positions
  localparam int SRC_SEL_BIT = 28;
  localparam int SEC1_BIT    = 25;
  localparam int SEC0_BIT    = 17;
  localparam int RECOV_BIT   = 25;
  localparam int FORCE_BIT   = 20;
  localparam int ICACHE_BIT  = 12;
  localparam int DCACHE_BIT  = 8;
  localparam int LPB_HI      = 15;
  localparam int LPB_LO      = 14;
  localparam int LPB_POL_BIT = 13;
  localparam int WDOG_EN_BIT = 10;
  localparam int WDOG_TO_HI  = 17;
  localparam int WDOG_TO_LO  = 16;
  localparam int DLY_HI      = 14;
  localparam int DLY_LO      = 8;
  localparam int SECOFF_HI   = 22;
  localparam int SECOFF_LO   = 19;
  localparam int PAD_HI      = 31;
  localparam int PAD_LO      = 24;
  localparam int FMODE_HI    = 11;
  localparam int FMODE_LO    = 8;
  localparam int FDEV_HI     = 7;
  localparam int FDEV_LO     = 4;

  // Decoded values
  localparam logic [15:0] WDOG_MS_00 = 16'h07D0;
  localparam logic [15:0] WDOG_MS_01 = 16'h05DC;
  localparam logic [15:0] WDOG_MS_10 = 16'h03E8;
  localparam logic [15:0] WDOG_MS_11 = 16'h01F4;
  localparam logic [10:0] SECOFF_N0_MB = 11'h004;
  localparam logic [10:0] SECOFF_N2_MB = 11'h001;
  localparam logic [3:0]  SECOFF_N_MAX = 4'hA;
  localparam logic [3:0]  SECOFF_NOR_MAX = 4'h7;

  // Bus constants and register offsets
  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
  localparam logic        HRESP_OKAY    = 1'h0;
  localparam logic [7:0]  REG_STATUS    = 8'h00;
  localparam logic [7:0]  REG_CTRL      = 8'h04;
  localparam logic [7:0]  REG_BOOTCFG   = 8'h08;
  localparam logic [7:0]  REG_CARD      = 8'h0C;
  localparam logic [7:0]  REG_PADS      = 8'h10;
  localparam logic [7:0]  REG_DIG_FIRST = 8'h20;
  localparam logic [7:0]  REG_DIG_LAST  = 8'h3C;
  localparam int          CTRL_HIDE_BIT = 0;

  typedef enum logic [1:0] {
    BFCD_MODE_FUSES    = 2'b00,
    BFCD_MODE_SERIAL   = 2'b01,
    BFCD_MODE_INTERNAL = 2'b10,
    BFCD_MODE_RSVD     = 2'b11
  } bfcdMode_t;

  typedef enum logic [1:0] {
    BFCD_SEC_RSVD   = 2'b00,
    BFCD_SEC_OPEN   = 2'b01,
    BFCD_SEC_CLOSED = 2'b10
  } bfcdSec_t;

  typedef enum logic [1:0] {
    BFCD_LPB_OFF  = 2'b00,
    BFCD_LPB_DIV2 = 2'b01,
    BFCD_LPB_DIV4 = 2'b10
  } bfcdLpb_t;

  typedef struct packed {
    logic       reserved;
    logic [1:0] pullUpDown;
    logic       pullKeepSel;
    logic       hysteresis;
    logic       slewRate;
    logic [1:0] driveStrength;
  } bfcdPad_t;

  typedef struct packed {
    bfcdMode_t   mode;
    logic [3:0]  device;
    logic        fuseSourced;
    logic        toDownloader;
    bfcdSec_t    sec;
    logic        secReserved;
    logic        recoveryEn;
    logic        icacheOff;
    logic        dcacheOff;
    bfcdLpb_t    lpbDiv;
    logic        lpbPolarity;
    logic        wdogOn;
    logic [15:0] wdogTimeoutMs;
    logic [6:0]  cardDelay;
    logic        secondaryEn;
    logic        secondaryNorOk;
    logic [10:0] secondaryOffsetMb;
    bfcdPad_t    cardPad;
    bfcdPad_t    nandPad;
  } bfcdCfg_t;

endpackage
